// ==== rtl/nfc_pkg.sv ====
// shared constants, command codes and types of the nand flash host controller
package nfc_pkg;
  // ==========================================================================
  // timing
  localparam int         CLK_NS      = 8;
  localparam int         STROBE_NS   = 25;
  localparam int         REA_NS      = 25;
  localparam int         WB_NS       = 100;
  localparam int         SYNC_STAGES = 3;
  localparam logic [7:0] STROBE_CYC  = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] READ_CYC    = 8'((REA_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  localparam logic [7:0] WB_CYC      = 8'((WB_NS + CLK_NS - 1) / CLK_NS);

  // ==========================================================================
  // array geometry and buffering
  localparam int          BLOCKS          = 4096;
  localparam int          PAGES_PER_BLOCK = 64;
  localparam logic [11:0] PAGE_BYTES      = 12'h840;
  localparam logic [11:0] STATUS_LEN      = 12'h001;
  localparam int          FIFO_WIDTH      = 8;
  localparam int          FIFO_DEPTH      = 32;

  // ==========================================================================
  // command codes
  localparam logic [7:0] CMD_READ_SETUP  = 8'h00;
  localparam logic [7:0] CMD_READ_GO     = 8'h30;
  localparam logic [7:0] CMD_PROG_SETUP  = 8'h80;
  localparam logic [7:0] CMD_PROG_GO     = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO    = 8'hD0;
  localparam logic [7:0] CMD_RESET       = 8'hFF;
  localparam logic [7:0] CMD_STATUS      = 8'h70;

  // ==========================================================================
  // address cycles
  localparam logic [2:0] ADDR_FIRST_COL = 3'h0;
  localparam logic [2:0] ADDR_COL_HI    = 3'h1;
  localparam logic [2:0] ADDR_FIRST_ROW = 3'h2;
  localparam logic [2:0] ADDR_ROW_MID   = 3'h3;
  localparam logic [2:0] ADDR_LAST      = 3'h4;
  localparam logic [7:0] COL_HI_MASK    = 8'h0F;
  localparam logic [7:0] ROW_HI_MASK    = 8'h03;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    OP_READ   = 3'h0,
    OP_PROG   = 3'h1,
    OP_ERASE  = 3'h2,
    OP_RESET  = 3'h3,
    OP_STATUS = 3'h4
  } nfc_op_type;

  typedef struct packed {
    nfc_op_type  op;
    logic [11:0] len;
    logic [23:0] row;
    logic [15:0] col;
  } nfc_cmd_type;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_CMD1    = 4'h1,
    ST_ADDR    = 4'h2,
    ST_DATA_W  = 4'h3,
    ST_DATA_WS = 4'h4,
    ST_CMD2    = 4'h5,
    ST_WAIT_WB = 4'h6,
    ST_WAIT_RB = 4'h7,
    ST_DATA_R  = 4'h8,
    ST_DONE    = 4'h9
  } nfc_state_type;
endpackage

// ==== rtl/nfc_host.sv ====
// nand flash host controller: write-data fifo and pin sequencer
`timescale 1ns/1ps

// ============================================================================
// write-data fifo
module nfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  input  wire logic             i_wr_valid,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_wr_ready,
  output logic                  o_rd_valid,
  output logic      [WIDTH-1:0] o_rd_data,
  input  wire logic             i_rd_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          ready;
    logic          valid;
  } nfc_fifo_state_type;

  nfc_fifo_state_type s;
  nfc_fifo_state_type n;
  logic [WIDTH-1:0]   mem [DEPTH];
  logic               push;
  logic               pop;

  always_comb begin
    n    = s;
    push = i_wr_valid && s.ready;
    pop  = i_rd_ready && s.valid;
    if (push) begin
      n.wp = s.wp + AW'(1);
    end
    if (pop) begin
      n.rp = s.rp + AW'(1);
    end
    n.cnt   = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // flags kept in flops so both handshakes come straight off registers
    n.ready = (n.cnt != (AW+1)'(DEPTH));
    n.valid = (n.cnt != '0);
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s       <= '0;
      s.ready <= 1'b1;
    end else if (i_ce) begin
      s <= n;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_ce && push) begin
      mem[s.wp] <= i_wr_data;
    end
  end

  assign o_wr_ready = s.ready;
  assign o_rd_valid = s.valid;
  assign o_rd_data  = mem[s.rp];
endmodule

// ============================================================================
// pin sequencer
// How it works
// - with command latch high, our byte is taken at the write strobe rise
// - with address latch high, our byte is taken at the write strobe rise
// - every byte we send is held on the bus across the strobe rise
// - stored data needs ecc correcting 4 bits per 512 bytes; this controller corrects nothing, ecc must be in the user stream
// - reset and status are one cycle; read, program, erase take two
module nfc_host (
  input  wire logic                 i_clock,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  input  wire logic                 i_cmd_valid,
  input  wire nfc_pkg::nfc_cmd_type i_cmd,
  output logic                      o_cmd_ready,
  output logic                      o_done,
  input  wire logic                 i_wr_valid,
  input  wire logic [7:0]           i_wr_data,
  output logic                      o_wr_ready,
  output logic                      o_rd_valid,
  output logic      [7:0]           o_rd_data,
  input  wire logic                 i_rd_ready,
  output logic                      o_cle,
  output logic                      o_ale,
  output logic                      o_ce_n,
  output logic                      o_we_n,
  output logic                      o_read_strobe_n,
  output logic                      o_wp_n,
  output logic      [7:0]           o_bus_io_out,
  output logic                      o_bus_io_oe,
  input  wire logic [7:0]           i_bus_io_in,
  input  wire logic                 i_rb_n
);
  typedef struct packed {
    nfc_pkg::nfc_state_type st;
    logic                   ph;
    logic [7:0]             cnt;
    logic [2:0]             acnt;
    logic [11:0]            idx;
    nfc_pkg::nfc_cmd_type   cmd;
    logic                   cle;
    logic                   ale;
    logic                   ce_n;
    logic                   we_n;
    logic                   re_n;
    logic                   wp_n;
    logic [7:0]             io_out;
    logic                   io_oe;
    logic                   cmd_ready;
    logic                   rd_valid;
    logic                   done;
    logic [7:0]             rd_data;
    logic [2:0]             rb_s;
    logic                   rb_ok;
    logic [7:0]             io_s0;
    logic [7:0]             io_s1;
    logic [7:0]             io_s2;
  } nfc_host_state_type;

  nfc_host_state_type s;
  nfc_host_state_type n;
  logic               f_valid;
  logic [7:0]         f_data;
  logic               pop;
  logic               wgo;
  logic               wr_fin;
  logic               rd_fin;

  // ==========================================================================
  // byte encoders
  function automatic logic [7:0] first_code(input nfc_pkg::nfc_op_type op);
    case (op)
      nfc_pkg::OP_READ:  first_code = nfc_pkg::CMD_READ_SETUP;
      nfc_pkg::OP_PROG:  first_code = nfc_pkg::CMD_PROG_SETUP;
      nfc_pkg::OP_ERASE: first_code = nfc_pkg::CMD_ERASE_SETUP;
      nfc_pkg::OP_RESET: first_code = nfc_pkg::CMD_RESET;
      default:           first_code = nfc_pkg::CMD_STATUS;
    endcase
  endfunction

  function automatic logic [7:0] second_code(input nfc_pkg::nfc_op_type op);
    case (op)
      nfc_pkg::OP_PROG:  second_code = nfc_pkg::CMD_PROG_GO;
      nfc_pkg::OP_ERASE: second_code = nfc_pkg::CMD_ERASE_GO;
      default:           second_code = nfc_pkg::CMD_READ_GO;
    endcase
  endfunction

  // unused high address bits forced low; device ignores extra cycles anyway
  function automatic logic [7:0] addr_byte(input logic [2:0] a,
                                           input nfc_pkg::nfc_cmd_type c);
    case (a)
      nfc_pkg::ADDR_FIRST_COL: addr_byte = c.col[7:0];
      nfc_pkg::ADDR_COL_HI:    addr_byte = c.col[15:8] & nfc_pkg::COL_HI_MASK;
      nfc_pkg::ADDR_FIRST_ROW: addr_byte = c.row[7:0];
      nfc_pkg::ADDR_ROW_MID:   addr_byte = c.row[15:8];
      default:                 addr_byte = c.row[23:16] & nfc_pkg::ROW_HI_MASK;
    endcase
  endfunction

  // ==========================================================================
  // sequencer
  always_comb begin
    n          = s;
    pop        = 1'b0;
    n.rd_valid = 1'b0;
    n.done     = 1'b0;
    n.io_oe    = 1'b0;
    n.wp_n     = 1'b1;
    n.rb_s     = {s.rb_s[1:0], i_rb_n}; // always driven, no float case
    if (s.rb_s[1] == s.rb_s[2]) begin
      n.rb_ok = s.rb_s[2];
    end
    n.io_s0 = i_bus_io_in;
    n.io_s1 = s.io_s0;
    n.io_s2 = s.io_s1;
    wgo     = (s.st == nfc_pkg::ST_CMD1) || (s.st == nfc_pkg::ST_ADDR) ||
              (s.st == nfc_pkg::ST_DATA_WS) || (s.st == nfc_pkg::ST_CMD2);
    wr_fin  = wgo && s.ph && (s.cnt == nfc_pkg::STROBE_CYC - 8'h01);
    rd_fin  = s.ph && (s.cnt == nfc_pkg::STROBE_CYC - 8'h01);

    // write cycle: drive byte, strobe low, rise latches it, then hold
    if (wgo) begin
      n.io_oe = 1'b1;
      case (s.st)
        nfc_pkg::ST_CMD1: n.io_out = first_code(s.cmd.op);
        nfc_pkg::ST_ADDR: n.io_out = addr_byte(s.acnt, s.cmd);
        nfc_pkg::ST_CMD2: n.io_out = second_code(s.cmd.op);
        default:          n.io_out = s.io_out;
      endcase
      n.cnt = s.cnt + 8'h01;
      if (!s.ph) begin
        n.we_n = 1'b0;
        if (s.cnt == nfc_pkg::STROBE_CYC - 8'h01) begin
          n.we_n = 1'b1;
          n.ph   = 1'b1;
          n.cnt  = 8'h00;
        end
      end else if (wr_fin) begin
        n.ph  = 1'b0;
        n.cnt = 8'h00;
      end
    end

    case (s.st)
      nfc_pkg::ST_IDLE: begin
        // page 0 is read by command, never assumed preloaded
        n.ce_n = 1'b1;
        if (i_cmd_valid && s.cmd_ready) begin
          n.cmd  = i_cmd;
          n.st   = nfc_pkg::ST_CMD1;
          n.ce_n = 1'b0;
          n.ph   = 1'b0;
          n.cnt  = 8'h00;
          n.idx  = 12'h000;
          n.acnt = (i_cmd.op == nfc_pkg::OP_ERASE) ? nfc_pkg::ADDR_FIRST_ROW
                                                   : nfc_pkg::ADDR_FIRST_COL;
          if (i_cmd.op == nfc_pkg::OP_STATUS) begin
            n.cmd.len = nfc_pkg::STATUS_LEN;
          end
        end
      end
      nfc_pkg::ST_CMD1: begin
        if (wr_fin) begin
          if (s.cmd.op == nfc_pkg::OP_RESET || s.cmd.op == nfc_pkg::OP_STATUS) begin
            n.st = nfc_pkg::ST_WAIT_WB;
          end else begin
            n.st = nfc_pkg::ST_ADDR;
          end
        end
      end
      nfc_pkg::ST_ADDR: begin
        if (wr_fin) begin
          if (s.acnt != nfc_pkg::ADDR_LAST) begin
            n.acnt = s.acnt + 3'h1;
          end else if (s.cmd.op == nfc_pkg::OP_PROG) begin
            n.st = nfc_pkg::ST_DATA_W;
          end else begin
            n.st = nfc_pkg::ST_CMD2;
          end
        end
      end
      nfc_pkg::ST_DATA_W: begin
        // ecc parity must already be in the user stream
        // every program reloads from the fifo; no cache or copy-back
        if (s.idx == s.cmd.len) begin
          n.st = nfc_pkg::ST_CMD2;
        end else if (f_valid) begin
          pop      = 1'b1;
          n.io_out = f_data;
          n.st     = nfc_pkg::ST_DATA_WS;
        end
      end
      nfc_pkg::ST_DATA_WS: begin
        if (wr_fin) begin
          n.idx = s.idx + 12'h001;
          n.st  = nfc_pkg::ST_DATA_W;
        end
      end
      nfc_pkg::ST_CMD2: begin
        if (wr_fin) begin
          n.st = nfc_pkg::ST_WAIT_WB;
        end
      end
      nfc_pkg::ST_WAIT_WB: begin
        // busy only shows after a delay, so do not look at it early
        // chip select stays low over the whole busy wait
        n.cnt = s.cnt + 8'h01;
        if (s.cnt == nfc_pkg::WB_CYC - 8'h01) begin
          n.cnt = 8'h00;
          n.st  = (s.cmd.op == nfc_pkg::OP_STATUS) ? nfc_pkg::ST_DATA_R
                                                   : nfc_pkg::ST_WAIT_RB;
        end
      end
      nfc_pkg::ST_WAIT_RB: begin
        // no time limit: page load, program and erase times vary
        if (s.rb_ok) begin
          n.st = (s.cmd.op == nfc_pkg::OP_READ) ? nfc_pkg::ST_DATA_R : nfc_pkg::ST_DONE;
        end
      end
      nfc_pkg::ST_DATA_R: begin
        if (!s.ph) begin
          if (s.cnt == 8'h00 && s.idx == s.cmd.len) begin
            n.st = nfc_pkg::ST_DONE;
          end else if (s.cnt != 8'h00 || i_rd_ready) begin
            n.re_n = 1'b0;
            n.cnt  = s.cnt + 8'h01;
            if (s.cnt == nfc_pkg::READ_CYC - 8'h01) begin
              // long low phase covers access time plus the synchroniser
              n.rd_data  = s.io_s2;
              n.rd_valid = 1'b1;
              n.re_n     = 1'b1;
              n.ph       = 1'b1;
              n.cnt      = 8'h00;
            end
          end
        end else begin
          n.cnt = s.cnt + 8'h01;
          if (rd_fin) begin
            n.idx = s.idx + 12'h001;
            n.ph  = 1'b0;
            n.cnt = 8'h00;
          end
        end
      end
      nfc_pkg::ST_DONE: begin
        n.done = 1'b1;
        n.ce_n = 1'b1;
        n.st   = nfc_pkg::ST_IDLE;
      end
      default: begin
        n.st = nfc_pkg::ST_IDLE;
      end
    endcase
    n.cle       = (n.st == nfc_pkg::ST_CMD1) || (n.st == nfc_pkg::ST_CMD2);
    n.ale       = (n.st == nfc_pkg::ST_ADDR);
    n.cmd_ready = (n.st == nfc_pkg::ST_IDLE) && (s.st == nfc_pkg::ST_IDLE) && !n.done;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s      <= '0;
      s.ce_n <= 1'b1;
      s.we_n <= 1'b1;
      s.re_n <= 1'b1;
    end else if (i_ce) begin
      s <= n;
    end
  end

  // ==========================================================================
  // write-data buffer
  nfc_fifo #(
    .WIDTH (nfc_pkg::FIFO_WIDTH),
    .DEPTH (nfc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clock    (i_clock),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_wr_valid (i_wr_valid),
    .i_wr_data  (i_wr_data),
    .o_wr_ready (o_wr_ready),
    .o_rd_valid (f_valid),
    .o_rd_data  (f_data),
    .i_rd_ready (pop)
  );

  assign o_cmd_ready     = s.cmd_ready;
  assign o_done          = s.done;
  assign o_rd_valid      = s.rd_valid;
  assign o_rd_data       = s.rd_data;
  assign o_cle           = s.cle;
  assign o_ale           = s.ale;
  assign o_ce_n          = s.ce_n;
  assign o_we_n          = s.we_n;
  assign o_read_strobe_n = s.re_n;
  assign o_wp_n          = s.wp_n;
  assign o_bus_io_out    = s.io_out;
  assign o_bus_io_oe     = s.io_oe;
endmodule

// ==== tb/nfc_host_properties.sv ====
// assertions on the pins and handshakes of the nand flash host controller
`timescale 1ns/1ps
module nfc_host_checker (
  input wire logic       i_clock,
  input wire logic       i_rst,
  input wire logic       o_cle,
  input wire logic       o_ale,
  input wire logic       o_ce_n,
  input wire logic       o_we_n,
  input wire logic       o_read_strobe_n,
  input wire logic       o_wp_n,
  input wire logic [7:0] o_bus_io_out,
  input wire logic       o_bus_io_oe,
  input wire logic       i_rb_n,
  input wire logic       o_rd_valid,
  input wire logic       o_done,
  input wire logic       o_cmd_ready
);
  // ==========================================================================
  // strobe shapes, latch, bus and protect rules, end of command
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  sequence s_we_pulse;
    (!o_we_n)[*3] ##1 o_we_n;
  endsequence
  sequence s_re_pulse;
    (!o_read_strobe_n)[*6] ##1 (o_read_strobe_n && o_rd_valid);
  endsequence
  sequence s_finish;
    o_ce_n && !o_cmd_ready ##1 o_cmd_ready;
  endsequence
  property p_we_pulse; $fell(o_we_n) |-> s_we_pulse; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe width wrong");
  property p_we_hold; $rose(o_we_n) |-> o_bus_io_oe && $stable(o_bus_io_out); endproperty
  a_we_hold: assert property (p_we_hold) else $error("bus moved at strobe rise");
  property p_cle_go; $rose(o_cle) |=> $fell(o_we_n); endproperty
  a_cle_go: assert property (p_cle_go) else $error("command strobe missing");
  property p_ale_go; $rose(o_ale) |=> $fell(o_we_n); endproperty
  a_ale_go: assert property (p_ale_go) else $error("address strobe missing");
  property p_excl; !(o_cle && o_ale); endproperty
  a_excl: assert property (p_excl) else $error("both latch enables high");
  property p_oe_sel; o_bus_io_oe |-> !o_ce_n && o_read_strobe_n; endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("bus driven while reading");
  property p_wp_write; $fell(o_we_n) |-> o_wp_n; endproperty
  a_wp_write: assert property (p_wp_write) else $error("strobe with protect on");
  property p_ready_cmd;
    $fell(o_we_n) && o_cle && !(o_bus_io_out inside {8'hFF, 8'h70}) |-> i_rb_n;
  endproperty
  a_ready_cmd: assert property (p_ready_cmd) else $error("command while busy");
  property p_read; $fell(o_read_strobe_n) |-> s_re_pulse; endproperty
  a_read: assert property (p_read) else $error("read strobe shape wrong");
  property p_done; o_done |-> s_finish; endproperty
  a_done: assert property (p_done) else $error("end of command wrong");
endmodule
bind nfc_host nfc_host_checker u_chk (.i_clock, .i_rst, .o_cle, .o_ale, .o_ce_n, .o_we_n,
  .o_read_strobe_n, .o_wp_n, .o_bus_io_out, .o_bus_io_oe, .i_rb_n, .o_rd_valid, .o_done,
  .o_cmd_ready);

// ==== tb/nfc_flash_model.sv ====
// behavioural nand flash device facing the host controller's pins
`timescale 1ns/1ps
module nfc_flash_model #(
  parameter int T_LOAD_NS  = 400,
  parameter int T_PROG_NS  = 800,
  parameter int T_ERASE_NS = 1600
) (
  input  wire logic       i_cle,
  input  wire logic       i_ale,
  input  wire logic       i_ce_n,
  input  wire logic       i_we_n,
  input  wire logic       i_read_strobe_n,
  input  wire logic       i_wp_n,
  input  wire logic [7:0] i_io,
  input  wire logic       i_io_oe,
  output logic      [7:0] o_bus_io,
  output logic            o_rb_n
);
  localparam int PAGE = 2112;  // 2K main plus 64 spare
  logic [7:0] mem [int];
  logic [7:0] preg [PAGE];
  logic [7:0] a [5];
  logic [7:0] cmd_ff = 8'h00;
  logic [7:0] op = 8'h00;
  logic [7:0] dout = 8'h00;
  logic       busy = 1'b0;
  int         acnt = 0;
  int         col = 0;
  int         base = 0;
  event       go;
  // ==========================================================================
  // pins
  assign o_rb_n = ~busy;  // driven high and low from busy, never floats
  // released bus shows the inverse of the last byte, not a stale copy
  assign o_bus_io = i_io_oe ? i_io : (!i_ce_n && !i_read_strobe_n) ? dout : ~dout;
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_cle && (!busy || i_io == 8'hFF || i_io == 8'h70)) begin
      cmd_ff = i_io;
      acnt = 0;
      if (i_io == 8'h80) preg = '{default: 8'hFF};
      if (i_io inside {8'h30, 8'h10, 8'hD0}) ->go;  // second code starts the work
    end else if (!i_ce_n && i_ale && acnt < 5) begin  // extra cycles ignored
      a[acnt] = i_io;
      acnt++;
      col = {a[1][3:0], a[0]};
    end else if (!i_ce_n && !i_cle && !i_ale && !busy) begin
      preg[col] = i_io;
      col++;
    end
  end
  always @(negedge i_read_strobe_n) begin  // one byte out, column up by one except after a status command
    if (!i_ce_n) begin
      dout = (cmd_ff == 8'h70) ? {i_wp_n, ~busy, 6'h00} : preg[col];
      if (cmd_ff != 8'h70) col++;
    end
  end
  // busy runs to the end whatever chip select does
  always @(go) begin
    busy = 1'b1;
    op = cmd_ff;
    base = (op == 8'hD0) ? {a[2][1:0], a[1], a[0]} : {a[4][1:0], a[3], a[2]};
    #(op == 8'h30 ? T_LOAD_NS : op == 8'h10 ? T_PROG_NS : T_ERASE_NS);
    for (int i = 0; i < PAGE && op != 8'hD0; i++) begin  // whole pages only
      if (op == 8'h30) preg[i] = mem.exists(base * PAGE + i) ? mem[base * PAGE + i] : 8'hFF;
      if (op == 8'h10 && i_wp_n) mem[base * PAGE + i] = preg[i];
    end
    for (int k = base / 64 * 64 * PAGE; op == 8'hD0 && k < (base / 64 + 1) * 64 * PAGE; k++)
      if (i_wp_n && mem.exists(k)) mem.delete(k);  // only whole 64-page blocks
    busy = 1'b0;
  end
endmodule

// ==== tb/test_nfc_host.sv ====
// self-checking bench of the nand flash host controller
`timescale 1ns/1ps
module test_nfc_host;
  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  logic                 cmd_valid = 1'b0;
  logic                 wr_valid = 1'b0;
  logic                 rd_ready = 1'b1;
  logic                 stall = 1'b0;
  logic                 ce = 1'b1;
  logic [7:0]           wr_data = 8'h00;
  nfc_pkg::nfc_cmd_type cmd = '0;
  logic                 cmd_ready, done, wr_ready, rd_valid, cle, ale, ce_n, we_n;
  logic                 re_n, wp_n, io_oe, rb_n;
  logic [7:0]           rd_data, io_out, io_in;
  logic [7:0]           rxq [$];
  int                   fail_count = 0;
  int                   n_checks = 0;
  // ==========================================================================
  // clock, stimulus helpers
  always #4 clock = ~clock;
  always @(negedge clock) rd_ready <= stall ? ~rd_ready : 1'b1;  // reader stalls half the time
  always @(negedge clock) if (rd_valid === 1'b1) rxq.push_back(rd_data);
  nfc_host u_dut (.i_clock(clock), .i_rst(rst), .i_ce(ce), .i_cmd_valid(cmd_valid),
    .i_cmd(cmd), .o_cmd_ready(cmd_ready), .o_done(done), .i_wr_valid(wr_valid),
    .i_wr_data(wr_data), .o_wr_ready(wr_ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
    .i_rd_ready(rd_ready), .o_cle(cle), .o_ale(ale), .o_ce_n(ce_n), .o_we_n(we_n),
    .o_read_strobe_n(re_n), .o_wp_n(wp_n), .o_bus_io_out(io_out), .o_bus_io_oe(io_oe),
    .i_bus_io_in(io_in), .i_rb_n(rb_n));
  nfc_flash_model u_mem (.i_cle(cle), .i_ale(ale), .i_ce_n(ce_n), .i_we_n(we_n),
    .i_read_strobe_n(re_n), .i_wp_n(wp_n), .i_io(io_out), .i_io_oe(io_oe), .o_bus_io(io_in),
    .o_rb_n(rb_n));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic stuck(input string what);
    fail_count++;
    $display("Error at %0t: timeout on %s", $time, what);
    finish_test();
  endtask
  task automatic run_cmd(input nfc_pkg::nfc_op_type op, input logic [11:0] len,
                         input logic [23:0] row);
    int n;
    @(negedge clock);
    rxq.delete();
    cmd = '{op: op, len: len, row: row, col: 16'h0000};
    cmd_valid = 1'b1;
    for (n = 0; cmd_ready !== 1'b1; n++) begin
      if (n > 100) stuck("accept");
      @(negedge clock);
    end
    @(negedge clock);
    cmd_valid = 1'b0;
    for (n = 0; done !== 1'b1; n++) begin
      if (n > 20000) stuck("done");
      @(negedge clock);
    end
  endtask
  task automatic push(input logic [7:0] b);
    int n;
    @(negedge clock);
    wr_valid = 1'b1;
    wr_data = b;
    for (n = 0; wr_ready !== 1'b1; n++) begin
      if (n > 2000) stuck("fifo");
      @(negedge clock);
    end
    @(negedge clock);
    wr_valid = 1'b0;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_idle;
    repeat (2) @(negedge clock);
    check({4'h0, ce_n, io_oe, wp_n, cmd_ready}, 8'h0B, "idle pins");
  endtask
  task automatic t_freeze;
    @(negedge clock);
    ce = 1'b0;
    cmd = '{op: nfc_pkg::OP_RESET, len: 12'h000, row: 24'h000000, col: 16'h0000};
    cmd_valid = 1'b1;
    repeat (3) @(negedge clock);
    check({6'h00, ce_n, cmd_ready}, 8'h03, "frozen take");
    cmd_valid = 1'b0;
    ce = 1'b1;
  endtask
  task automatic t_prog_read(input logic [23:0] row);
    for (int i = 0; i < 32; i++) push(8'(i * 37 + 5)); // ecc already in user bytes
    @(negedge clock);
    check({7'h00, wr_ready}, 8'h00, "fifo full");
    run_cmd(nfc_pkg::OP_PROG, 12'h020, row);
    stall = 1'b1;
    run_cmd(nfc_pkg::OP_READ, 12'h020, row);
    stall = 1'b0;
    check(8'(rxq.size()), 8'h20, "read count");
    for (int i = 0; i < 32; i++) check(rxq[i], 8'(i * 37 + 5), "page byte");
  endtask
  task automatic t_erase(input logic [23:0] row);
    run_cmd(nfc_pkg::OP_ERASE, 12'h000, row + 24'h000001);
    run_cmd(nfc_pkg::OP_READ, 12'h004, row);
    check(8'(rxq.size()), 8'h04, "erase read count");
    foreach (rxq[i]) check(rxq[i], 8'hFF, "erased byte");
  endtask
  task automatic t_status;
    run_cmd(nfc_pkg::OP_STATUS, 12'h001, 24'h000000);
    check(8'(rxq.size()), 8'h01, "status count");
    check(rxq[0], 8'hC0, "status byte");
  endtask
  task automatic t_reset_cmd;
    run_cmd(nfc_pkg::OP_RESET, 12'h000, 24'h000000);
    @(negedge clock);
    check({6'h00, ce_n, cmd_ready}, 8'h03, "after reset command");
  endtask
  initial begin
    repeat (6) @(posedge clock);
    @(negedge clock);
    check({7'h00, wp_n}, 8'h00, "protect in reset");
    rst = 1'b0;
    t_idle();
    t_freeze();
    t_prog_read(24'h000041);
    t_erase(24'h000041);
    t_status();
    t_reset_cmd();
    finish_test();
  end
endmodule
